/* verilog/fptd_pkg.sv */
// Summary of operation
// - Single and double formats only, no extended.
// - Nearest and chopped rounding; infinities optional too.
// - Add, sub, mul, div, conversions, compare.
// - Loads, stores, sign copies move bits untouched.
// - Compare same-format operands, true/false answer.
// - Six ordered predicates plus unordered in hardware.
// - Trap on infinity operand, overflow, divide-by-zero.
// - Trap on NaN operand or NaN creation.
// - Accept minus zero; signed zero results correct.
// - Tininess detected after rounding; inexact separate.
// - Trap set is superset; software finishes.
// - Trap choice only from instruction bits.
// - Untrapped underflow gives plus zero, no trap.
// - Trapped underflow gives plus zero and traps.
package fptd_pkg;
  // Operation codes from issue
  typedef enum logic [3:0] {
    fp_load_op, fp_store_op, fp_sign_copy_op, fp_sign_copy_neg_op,
    fp_add_op, fp_sub_op, fp_mul_op, fp_div_op,
    fp_cvt_fmt_op, fp_cvt_to_int_op, fp_cvt_from_int_op, fp_cmp_op
  } fptd_op_t;
  // Compare predicates held by hardware
  typedef enum logic [2:0] {
    PRED_EQ, PRED_NE, PRED_LT, PRED_LE, PRED_GT, PRED_GE, PRED_UN
  } fptd_pred_t;
  // Rounding modes handed to the arithmetic core
  typedef enum logic [1:0] {RND_NEAREST, RND_CHOP, RND_PLUS, RND_MINUS} fptd_rnd_t;
  // Double layout
  localparam int DBL_SIGN = 63;
  localparam int DBL_EXP_HI = 62;
  localparam int DBL_EXP_LO = 52;
  localparam int DBL_FRAC_HI = 51;
  // Single layout, in the low word
  localparam int SGL_SIGN = 31;
  localparam int SGL_EXP_HI = 30;
  localparam int SGL_EXP_LO = 23;
  localparam int SGL_FRAC_HI = 22;
  // Trap cause bit positions
  localparam int CAUSE_NONFIN = 0;
  localparam int CAUSE_NAN = 1;
  localparam int CAUSE_DZE = 2;
  localparam int CAUSE_OVF = 3;
  localparam int CAUSE_UNF = 4;
  localparam int CAUSE_INE = 5;
  localparam int CAUSE_W = 6;
  // Reset and fixed values
  localparam logic [63:0] ZERO_WORD = 64'h0;
  localparam logic [63:0] CMP_TRUE_WORD = 64'h4000000000000000;
  localparam logic [CAUSE_W-1:0] CAUSE_NONE = 6'h0;
endpackage

/* verilog/fptd_unit.sv */
`timescale 1ns/1ps
module fptd_unit
  import fptd_pkg::*;
(
  input wire logic ref_clk, // Core clock, 100 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic opValid, // Instruction issued this cycle
  input wire fptd_op_t opCode, // Operation
  input wire logic fmtDouble, // 1 double, 0 single
  input wire fptd_rnd_t roundMode, // Rounding mode of the instruction
  input wire logic trapUnfEn, // Underflow trap enable bit of the encoding
  input wire logic trapIneEn, // Inexact trap enable bit of the encoding
  input wire fptd_pred_t cmpPred, // Compare predicate
  input wire logic [63:0] opA, // Operand A
  input wire logic [63:0] opB, // Operand B
  input wire logic [63:0] coreResult, // Rounded result of the arithmetic core
  input wire logic coreOverflow, // Core: exponent overflow
  input wire logic coreTiny, // Core: tiny after rounding
  input wire logic coreInexact, // Core: inexact result
  input wire logic coreInvalid, // Core: result would be a NaN
  output logic resultValid, // Result and trap valid, one cycle
  output logic [63:0] result, // Result word
  output logic cmpTrue, // Compare outcome
  output logic trapOut, // Hardware trap request
  output logic [CAUSE_W-1:0] trapCause // Trap causes
);
  // Per-operand classification: A, B and core result
  logic [63:0] word [3];
  logic isSign [3];
  logic isZero [3];
  logic isInf [3];
  logic isNan [3];
  logic isDen [3];
  logic [62:0] mag [3];
  assign word[0] = opA;
  assign word[1] = opB;
  assign word[2] = coreResult;
  // Field decode chosen by format, no extended format exists
  for (genvar i = 0; i < 3; i++) begin : g_cls
    logic expOnes;
    logic expZero;
    logic fracZero;
    assign isSign[i] = fmtDouble ? word[i][DBL_SIGN] : word[i][SGL_SIGN];
    assign expOnes = fmtDouble ? &word[i][DBL_EXP_HI:DBL_EXP_LO]
                               : &word[i][SGL_EXP_HI:SGL_EXP_LO];
    assign expZero = fmtDouble ? ~|word[i][DBL_EXP_HI:DBL_EXP_LO]
                               : ~|word[i][SGL_EXP_HI:SGL_EXP_LO];
    assign fracZero = fmtDouble ? ~|word[i][DBL_FRAC_HI:0] : ~|word[i][SGL_FRAC_HI:0];
    assign isZero[i] = expZero & fracZero; // Either sign of zero accepted
    assign isDen[i] = expZero & ~fracZero;
    assign isInf[i] = expOnes & fracZero;
    assign isNan[i] = expOnes & ~fracZero;
    assign mag[i] = fmtDouble ? word[i][62:0] : {32'h0, word[i][30:0]};
  end

  // Operation class decode
  wire isMove = (opCode == fp_load_op) | (opCode == fp_store_op)
              | (opCode == fp_sign_copy_op) | (opCode == fp_sign_copy_neg_op);
  wire isAddSub = (opCode == fp_add_op) | (opCode == fp_sub_op);
  wire isMulDiv = (opCode == fp_mul_op) | (opCode == fp_div_op);
  wire isCvtF = (opCode == fp_cvt_fmt_op) | (opCode == fp_cvt_to_int_op);
  wire isArith = isAddSub | isMulDiv | isCvtF | (opCode == fp_cvt_from_int_op);
  wire isCmp = opCode == fp_cmp_op;
  wire useA = isAddSub | isMulDiv;
  wire useB = isAddSub | isMulDiv | isCvtF;

  // Operand hazards; integer source of a conversion is not classified
  wire opNonfin = (useA & (isInf[0] | isDen[0])) | (useB & (isInf[1] | isDen[1]));
  wire opNan = (useA & isNan[0]) | (useB & isNan[1]);
  // Divide by zero needs a finite, nonzero dividend; 0/0 makes a NaN instead
  wire divZero = (opCode == fp_div_op) & isZero[1] & ~isZero[0]
               & ~isNan[0] & ~isInf[0];
  wire nanMake = ((opCode == fp_div_op) & isZero[0] & isZero[1]) | coreInvalid;
  wire underflow = coreTiny; // Tininess flagged by the core after rounding

  // Cause vector: instruction bits alone gate optional traps
  logic [CAUSE_W-1:0] arithCause;
  assign arithCause[CAUSE_NONFIN] = opNonfin;
  assign arithCause[CAUSE_NAN] = opNan | nanMake;
  assign arithCause[CAUSE_DZE] = divZero;
  assign arithCause[CAUSE_OVF] = coreOverflow;
  assign arithCause[CAUSE_UNF] = underflow & trapUnfEn;
  assign arithCause[CAUSE_INE] = coreInexact & trapIneEn;
  wire [CAUSE_W-1:0] cmpCause = {4'h0, isNan[0] | isNan[1], 1'b0};
  // Moves never raise anything, even for a signaling NaN
  wire [CAUSE_W-1:0] nxtCause = isArith ? arithCause : (isCmp ? cmpCause : CAUSE_NONE);

  // Compare of same-format operands, sign-magnitude ordering
  wire unord = isNan[0] | isNan[1];
  wire bothZero = isZero[0] & isZero[1];
  // Magnitude order of the two operands, sign handled below
  wire magLt = mag[0] < mag[1];
  wire magGt = mag[1] < mag[0];
  wire eqRaw = bothZero | (mag[0] == mag[1] & isSign[0] == isSign[1]);
  wire ltRaw = ~bothZero & ((isSign[0] & ~isSign[1])
             | (~isSign[0] & ~isSign[1] & magLt) | (isSign[0] & isSign[1] & magGt));
  wire eqOrd = ~unord & eqRaw;
  wire ltOrd = ~unord & ltRaw;
  wire gtOrd = ~unord & ~eqRaw & ~ltRaw;
  logic predHit;
  // Predicate select, seven predicates in hardware
  always_comb begin
    unique case (cmpPred)
      PRED_EQ: predHit = eqOrd;
      PRED_NE: predHit = ~eqOrd;
      PRED_LT: predHit = ltOrd;
      PRED_LE: predHit = ltOrd | eqOrd;
      PRED_GT: predHit = gtOrd;
      PRED_GE: predHit = gtOrd | eqOrd;
      PRED_UN: predHit = unord;
      default: predHit = 1'b0;
    endcase
  end

  // Signed zero of an exact zero result
  wire effSignB = isSign[1] ^ (opCode == fp_sub_op);
  wire addZeroSign = (isSign[0] == effSignB) ? isSign[0] : (roundMode == RND_MINUS);
  wire zeroSign = isAddSub ? addZeroSign : (isMulDiv ? isSign[0] ^ isSign[1] : isSign[2]);
  wire [63:0] signedZero = fmtDouble ? {zeroSign, 63'h0} : {32'h0, zeroSign, 31'h0};
  // Underflow always yields a true plus zero
  wire [63:0] arithWord = underflow ? ZERO_WORD : (isZero[2] ? signedZero : coreResult);
  // Sign copy: sign of A onto B
  wire copySign = isSign[0] ^ (opCode == fp_sign_copy_neg_op);
  wire [63:0] copyWord = fmtDouble ? {copySign, opB[62:0]}
                                   : {opB[63:32], copySign, opB[30:0]};
  logic [63:0] nxtResult;
  // Result select
  always_comb begin
    unique case (opCode)
      fp_load_op, fp_store_op: nxtResult = opA;
      fp_sign_copy_op, fp_sign_copy_neg_op: nxtResult = copyWord;
      fp_cmp_op: nxtResult = predHit ? CMP_TRUE_WORD : ZERO_WORD;
      fp_add_op, fp_sub_op, fp_mul_op, fp_div_op,
      fp_cvt_fmt_op, fp_cvt_to_int_op, fp_cvt_from_int_op: nxtResult = arithWord;
      default: nxtResult = ZERO_WORD;
    endcase
  end

  // Output stage
  logic resultValid_ff;
  logic [63:0] result_ff;
  logic cmpTrue_ff;
  logic [CAUSE_W-1:0] cause_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      resultValid_ff <= 1'b0;
      result_ff <= ZERO_WORD;
      cmpTrue_ff <= 1'b0;
      cause_ff <= CAUSE_NONE;
    end else begin
      resultValid_ff <= opValid;
      result_ff <= opValid ? nxtResult : ZERO_WORD;
      cmpTrue_ff <= opValid & isCmp & predHit;
      cause_ff <= opValid ? nxtCause : CAUSE_NONE;
    end
  end
  assign resultValid = resultValid_ff;
  assign result = result_ff;
  assign cmpTrue = cmpTrue_ff;
  assign trapCause = cause_ff;
  assign trapOut = |cause_ff;

  // Checks, all on the core clock and quiet during reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Moves pass bits through and stay silent
  move_no_trap_a: assert property (opValid && isMove |=> !trapOut)
    else $error("move raised a trap");
  load_bits_a: assert property (opValid && opCode == fp_load_op
    |=> result == $past(opA))
    else $error("load altered bits");

  // Underflow gives a true plus zero, trapping only on request
  unf_plus_zero_a: assert property (opValid && isArith && coreTiny
    |=> result == ZERO_WORD)
    else $error("underflow result not plus zero");
  unf_quiet_a: assert property (opValid && isArith && coreTiny && !trapUnfEn
    |=> !trapCause[CAUSE_UNF])
    else $error("disabled underflow trapped");
  unf_trap_a: assert property (opValid && isArith && coreTiny && trapUnfEn
    |=> trapOut && trapCause[CAUSE_UNF])
    else $error("enabled underflow did not trap");

  // Non-finite operands and results of arithmetic ops always trap
  nan_trap_a: assert property (opValid && isArith && opNan
    |=> trapOut && trapCause[CAUSE_NAN])
    else $error("NaN operand did not trap");
  nan_make_a: assert property (opValid && isArith && coreInvalid
    |=> trapOut && trapCause[CAUSE_NAN])
    else $error("NaN creation did not trap");
  inf_trap_a: assert property (opValid && isAddSub && (isInf[0] || isInf[1])
    |=> trapCause[CAUSE_NONFIN])
    else $error("infinity operand did not trap");
  ovf_trap_a: assert property (opValid && isArith && coreOverflow
    |=> trapOut && trapCause[CAUSE_OVF])
    else $error("overflow did not trap");
  div_zero_a: assert property (opValid && opCode == fp_div_op && isZero[1]
    && !isZero[0] && !isNan[0] && !isInf[0] |=> trapCause[CAUSE_DZE])
    else $error("divide by zero did not trap");

  // Inexact traps only when the instruction carries its enable
  ine_gate_a: assert property (opValid && !trapIneEn
    |=> !trapCause[CAUSE_INE])
    else $error("inexact trapped without enable");

  // Compare outcomes
  cmp_unord_a: assert property (opValid && isCmp && cmpPred == PRED_UN && unord
    |=> cmpTrue && result == CMP_TRUE_WORD)
    else $error("unordered predicate missed");
  unord_false_a: assert property (opValid && isCmp && unord
    && cmpPred inside {PRED_EQ, PRED_LT, PRED_LE, PRED_GT, PRED_GE} |=> !cmpTrue)
    else $error("ordered predicate true on NaN");
  cmp_quiet_a: assert property (opValid && isCmp && !unord |=> !trapOut)
    else $error("ordered compare trapped");
  zero_equal_a: assert property (opValid && isCmp && cmpPred == PRED_EQ
    && isZero[0] && isZero[1] |=> cmpTrue)
    else $error("signed zeros not equal");

  // Signed zero of a product
  mul_zero_sign_a: assert property (opValid && opCode == fp_mul_op && fmtDouble
    && isZero[2] && !coreTiny
    |=> result[DBL_SIGN] == ($past(opA[DBL_SIGN]) ^ $past(opB[DBL_SIGN])))
    else $error("product zero sign wrong");

  // One answer per issue, nothing between issues
  valid_follow_a: assert property (opValid
    |=> resultValid ##1 (resultValid == $past(opValid)))
    else $error("result valid timing wrong");
  idle_quiet_a: assert property (!opValid
    |=> !resultValid && !trapOut && result == ZERO_WORD)
    else $error("output active without an issue");
endmodule

/* verification/fptd_core_model.sv */
`timescale 1ns/1ps
// Arithmetic core beside the unit: shows the rounded value and flags for the op at issue
module fptd_core_model (
  input wire logic [63:0] setRes, // Rounded value chosen for this op
  input wire logic [3:0] setFlags, // {overflow, tiny, inexact, invalid}
  output logic [63:0] coreResult, // Rounded result
  output logic coreOverflow, // Exponent overflow
  output logic coreTiny, // Tiny after rounding
  output logic coreInexact, // Inexact result
  output logic coreInvalid // Result would be a NaN
);
  // Same-cycle answer, tininess judged after rounding
  assign coreResult = setRes;
  assign {coreOverflow, coreTiny, coreInexact, coreInvalid} = setFlags;
endmodule

/* verification/test_fptd_unit.sv */
`timescale 1ns/1ps
module test_fptd_unit
  import fptd_pkg::*;
();
  localparam logic [63:0] ONE = 64'h3ff0000000000000, TWO = 64'h4000000000000000;
  localparam logic [63:0] MONE = 64'hbff0000000000000, INF = 64'h7ff0000000000000;
  localparam logic [63:0] SNAN = 64'h7ff4000000000000, NZ = 64'h8000000000000000;
  localparam logic [63:0] SONE = 64'h3f800000, SMONE = 64'hbf800000, SINF = 64'h7f800000;
  logic ref_clk = 0, rst_n = 0, opValid = 0, fmtDouble = 1, trapUnfEn = 0, trapIneEn = 0;
  fptd_op_t opCode = fp_load_op; // Operation at issue
  fptd_rnd_t roundMode = RND_NEAREST; // Rounding mode
  fptd_pred_t cmpPred = PRED_EQ; // Predicate
  logic [63:0] opA = 64'h0, opB = 64'h0, setRes = 64'h0, coreResult, result;
  logic [3:0] setFlags = 4'h0;
  logic coreOverflow, coreTiny, coreInexact, coreInvalid, resultValid, cmpTrue, trapOut;
  logic [CAUSE_W-1:0] trapCause;
  int failures = 0, n_checks = 0;
  // Clock at 100 MHz
  always #5 ref_clk = ~ref_clk;
  fptd_core_model fptd_core_model_i (.setRes(setRes), .setFlags(setFlags),
    .coreResult(coreResult), .coreOverflow(coreOverflow), .coreTiny(coreTiny),
    .coreInexact(coreInexact), .coreInvalid(coreInvalid));
  fptd_unit fptd_unit_i (.ref_clk(ref_clk), .rst_n(rst_n), .opValid(opValid), .opCode(opCode),
    .fmtDouble(fmtDouble), .roundMode(roundMode), .trapUnfEn(trapUnfEn),
    .trapIneEn(trapIneEn), .cmpPred(cmpPred), .opA(opA), .opB(opB), .coreResult(coreResult),
    .coreOverflow(coreOverflow), .coreTiny(coreTiny), .coreInexact(coreInexact),
    .coreInvalid(coreInvalid), .resultValid(resultValid), .result(result), .cmpTrue(cmpTrue),
    .trapOut(trapOut), .trapCause(trapCause));
  // Issue one op, then judge the one-cycle answer
  task automatic run(input fptd_op_t c, input logic [63:0] a, b, r, input logic [3:0] f,
      input logic [63:0] er, input logic [5:0] ec, input logic ecmp);
    logic [72:0] got, exp; // Answer seen and answer wanted
    opCode = c;
    opA = a;
    opB = b;
    setRes = r;
    setFlags = f;
    opValid = 1;
    @(posedge ref_clk) #1;
    opValid = 0;
    opA = ~a;
    opB = ~b;
    got = {resultValid, cmpTrue, trapOut, result, trapCause};
    exp = {1'b1, ecmp, |ec, er, ec};
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Moves keep bits and never trap, signalling NaN included
  task automatic t_moves;
    run(fp_load_op, SNAN, ONE, 64'h0, 4'h0, SNAN, 6'h0, 0);
    run(fp_store_op, INF, ONE, 64'h0, 4'h0, INF, 6'h0, 0);
    run(fp_sign_copy_neg_op, ONE, SNAN, 64'h0, 4'h0, 64'hfff4000000000000, 6'h0, 0);
    fmtDouble = 0;
    run(fp_sign_copy_op, 64'h80000000, 64'h1234567800000001, 64'h0, 4'h0,
        64'h1234567880000001, 6'h0, 0);
    fmtDouble = 1;
  endtask
  // Every predicate, ordered and unordered, plus signed zeros
  task automatic t_cmp;
    logic [6:0] ordHit; // Predicates true for 1.0 against 2.0
    logic [6:0] nanHit; // Predicates true with a NaN operand
    ordHit = 7'h0e;
    nanHit = 7'h42;
    for (int p = 0; p < 7; p++) begin
      cmpPred = fptd_pred_t'(p);
      run(fp_cmp_op, ONE, TWO, 64'h0, 4'h0, ordHit[p] ? CMP_TRUE_WORD : ZERO_WORD, 6'h0,
          ordHit[p]);
      run(fp_cmp_op, SNAN, ONE, 64'h0, 4'h0, nanHit[p] ? CMP_TRUE_WORD : ZERO_WORD, 6'h2,
          nanHit[p]);
    end
    cmpPred = PRED_EQ;
    run(fp_cmp_op, NZ, 64'h0, 64'h0, 4'h0, TWO, 6'h0, 1);
  endtask
  // Non-finite operands and results trap back to back; inexact traps only with its enable
  task automatic t_traps;
    run(fp_add_op, INF, ONE, INF, 4'h0, INF, 6'h1, 0);
    run(fp_div_op, ONE, 64'h0, INF, 4'h0, INF, 6'h4, 0);
    run(fp_mul_op, TWO, TWO, INF, 4'h8, INF, 6'h8, 0);
    run(fp_sub_op, ONE, SNAN, SNAN, 4'h0, SNAN, 6'h2, 0);
    run(fp_div_op, 64'h0, 64'h0, SNAN, 4'h1, SNAN, 6'h2, 0);
    run(fp_add_op, ONE, TWO, TWO, 4'h2, TWO, 6'h0, 0);
    trapIneEn = 1;
    run(fp_add_op, ONE, TWO, TWO, 4'h2, TWO, 6'h20, 0);
    trapIneEn = 0;
  endtask
  // Underflow gives plus zero; underflow traps only when the instruction asks, a denormal operand always
  task automatic t_unf;
    run(fp_mul_op, NZ | 64'h1, ONE, NZ, 4'h4, 64'h0, 6'h1, 0);
    run(fp_mul_op, MONE, ONE, NZ, 4'h4, 64'h0, 6'h0, 0);
    trapUnfEn = 1;
    run(fp_mul_op, MONE, ONE, NZ, 4'h4, 64'h0, 6'h10, 0);
    trapUnfEn = 0;
  endtask
  // Single format in the low word; the high word never matters to classification or compare
  task automatic t_single;
    fmtDouble = 0;
    run(fp_add_op, SINF, SONE, SINF, 4'h0, SINF, 6'h1, 0);
    run(fp_div_op, SONE, ONE, SINF, 4'h0, SINF, 6'h4, 0);
    cmpPred = PRED_LT;
    run(fp_cmp_op, INF | SMONE, SONE, 64'h0, 4'h0, CMP_TRUE_WORD, 6'h0, 1);
    cmpPred = PRED_EQ;
    run(fp_mul_op, SMONE, 64'h0, 64'h0, 4'h0, 64'h80000000, 6'h0, 0);
    fmtDouble = 1;
  endtask
  // Conversions check only their float source; an integer source is not classified
  task automatic t_cvt;
    run(fp_cvt_to_int_op, SNAN, INF, 64'h0, 4'h0, 64'h0, 6'h1, 0);
    run(fp_cvt_fmt_op, ONE, SNAN, SNAN, 4'h0, SNAN, 6'h2, 0);
    run(fp_cvt_from_int_op, INF, SNAN, TWO, 4'h0, TWO, 6'h0, 0);
  endtask
  // Signed zero results
  task automatic t_zero;
    run(fp_add_op, ONE, MONE, 64'h0, 4'h0, 64'h0, 6'h0, 0);
    roundMode = RND_PLUS;
    run(fp_add_op, ONE, MONE, 64'h0, 4'h0, 64'h0, 6'h0, 0);
    roundMode = RND_MINUS;
    run(fp_add_op, ONE, MONE, 64'h0, 4'h0, NZ, 6'h0, 0);
    roundMode = RND_CHOP;
    run(fp_add_op, NZ, NZ, 64'h0, 4'h0, NZ, 6'h0, 0);
    run(fp_mul_op, MONE, 64'h0, 64'h0, 4'h0, NZ, 6'h0, 0);
  endtask
  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1;
    t_moves();
    t_cmp();
    t_traps();
    t_unf();
    t_single();
    t_cvt();
    t_zero();
    summarize();
  end
  // Watchdog
  initial begin
    #20000 failures++;
    summarize();
  end
endmodule
